// ===== phase_comp_rms_calc.sv
/*
  Voltage path phase trim and current / voltage rms computation, with
  software registers on a plain strobe port and an rms waveform stream.
  Assumes samples are synchronous to clk_in and zero_cross_in is a
  one-cycle pulse from the voltage zero-crossing logic on the same clock.
*/
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module phase_comp_rms_calc
  import phase_rms_pkg::*;
#(
  parameter int WAVE_BASE_CYCLES = `WAVE_BASE_CYCLES
)(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [23:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [23:0] rdata_out,
  input  wire logic [23:0] cur_sample_in,
  input  wire logic [23:0] volt_sample_in,
  input  wire logic        zero_cross_in,
  output logic      [23:0] cur_aligned_out,
  output logic      [23:0] volt_aligned_out,
  output logic             sample_tick_out,
  output logic      [23:0] wave_sample_out,
  output logic             wave_valid_out
);
  main_state_t q;
  main_state_t n;

  // history of raw samples; the current path is held back by the largest
  // advance so that the voltage path can be moved both ways around it
  logic [23:0] cur_mem  [256];
  logic [23:0] volt_mem [256];

  sqrt_if root_bus ();

  isqrt_unit u_root (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .port     (root_bus.solver)
  );

  assign root_bus.start    = q.start;
  assign root_bus.radicand = q.rad;

  logic              step_now;
  logic              cur_ok;
  logic              volt_ok;
  logic [7:0]        cur_lag;
  logic [7:0]        volt_lag;
  logic [23:0]       cur_pick;
  logic [23:0]       volt_pick;
  logic [47:0]       sq_i;
  logic [47:0]       sq_v;
  logic [47:0]       mean_i;
  logic [47:0]       mean_v;
  logic signed [50:0] cor_i;
  logic signed [26:0] cor_v;
  logic [23:0]       irms_sat;
  logic [23:0]       voltage_rms_result_calc;
  logic [14:0]       wave_period;
  logic [1:0]        wave_src;
  logic              zx_mode;
  logic signed [7:0] wr_phase;

  assign step_now = (q.step_cnt == 6'(`STEP_CYCLES - 1));
  // fixed current lag equals the deepest advance, 190 steps
  assign cur_lag  = 8'(`PHASE_CENTRE - `PHASE_MIN);
  // voltage lag = fixed lag + (code - centre), which folds to code - min
  assign volt_lag = q.phase - `PHASE_MIN;
  // history slots not yet written read as zero, so no unknown from an
  // unwritten slot can poison the averaging accumulators forever
  assign cur_ok    = q.hist_full || (q.wr_ptr >= cur_lag);
  assign volt_ok   = q.hist_full || (q.wr_ptr >= volt_lag);
  assign cur_pick  = (cur_lag == 8'h00) ? cur_sample_in :
                     (cur_ok ? cur_mem[8'(q.wr_ptr - cur_lag)] : `RST_RESULT);
  assign volt_pick = (volt_lag == 8'h00) ? volt_sample_in :
                     (volt_ok ? volt_mem[8'(q.wr_ptr - volt_lag)] : `RST_RESULT);

  always_ff @(posedge clk_in) begin
    if (step_now) begin
      cur_mem[q.wr_ptr]  <= cur_sample_in;
      volt_mem[q.wr_ptr] <= volt_sample_in;
    end
  end

  assign sq_i   = 48'($signed(q.cur_al) * $signed(q.cur_al));
  assign sq_v   = 48'($signed(q.volt_al) * $signed(q.volt_al));
  assign mean_i = q.acc_i[63:`LPF_SHIFT];
  assign mean_v = q.acc_v[63:`LPF_SHIFT];

  // square-domain correction for current, weighted 2^15 per offset LSB
  assign cor_i = $signed({3'b000, mean_i})
               + $signed({{24{q.irms_os[11]}}, q.irms_os, 15'h0000});
  // linear correction for voltage, 64 result LSBs per offset LSB
  assign cor_v = $signed({2'b00, root_bus.root})
               + $signed({{9{q.voltage_rms_result_os[11]}}, q.voltage_rms_result_os, 6'h00});

  always_comb begin
    if (|q.irms_raw[24]) begin
      irms_sat = `RMS_MAX;
    end else begin
      irms_sat = q.irms_raw[23:0];
    end
    if (cor_v < 0) begin
      voltage_rms_result_calc = `RST_RESULT;
    end else if (cor_v[26:24] != 3'h0) begin
      voltage_rms_result_calc = `RMS_MAX;
    end else begin
      voltage_rms_result_calc = cor_v[23:0];
    end
  end

  assign wave_src    = q.wave_sel[`WAVE_SRC_MSB:`WAVE_SRC_LSB];
  assign wave_period = 15'(WAVE_BASE_CYCLES << q.wave_sel[`WAVE_RATE_MSB:`WAVE_RATE_LSB]);
  assign zx_mode     = q.mode_control_two[`BIT_ZX_RMS];
  assign wr_phase    = $signed(wdata_in[7:0]);

  always_comb begin
    n            = q;
    n.tick       = 1'b0;
    n.start      = 1'b0;
    n.wave_valid = 1'b0;
    n.rdata      = `RST_RESULT;

    // step timebase: one voltage delay step per 61 clocks, 1.22 us
    if (step_now) begin
      n.step_cnt = 6'h00;
      n.tick     = 1'b1;
      n.wr_ptr   = q.wr_ptr + 8'h01;
      if (q.wr_ptr == `HIST_LAST) begin
        n.hist_full = 1'b1;
      end
      n.cur_al   = cur_pick;
      n.volt_al  = volt_pick;
    end else begin
      n.step_cnt = q.step_cnt + 6'h01;
    end

    // averaging: acc holds mean scaled by 2^16, about a 2 Hz corner
    if (q.tick) begin
      n.acc_i = q.acc_i + {16'h0000, sq_i} - {16'h0000, mean_i};
      n.acc_v = q.acc_v + {16'h0000, sq_v} - {16'h0000, mean_v};
    end

    // root sequencing; one shared root unit serves both channels in turn,
    // which fits easily inside the 61-cycle step
    case (q.seq)
      SEQ_IDLE: begin
        if (q.tick) begin
          n.start = 1'b1;
          n.rad   = (cor_i < 0) ? 50'h0 : cor_i[49:0];
          n.seq   = SEQ_ROOT_I;
        end
      end
      SEQ_ROOT_I: begin
        if (root_bus.done) begin
          n.irms_raw = root_bus.root;
          n.start    = 1'b1;
          n.rad      = {2'b00, mean_v};
          n.seq      = SEQ_ROOT_V;
        end
      end
      SEQ_ROOT_V: begin
        if (root_bus.done) begin
          n.voltage_rms_result_new = voltage_rms_result_calc;
          n.seq      = SEQ_IDLE;
          if (!zx_mode) begin
            n.irms = irms_sat;
            n.voltage_rms_result = voltage_rms_result_calc;
          end
        end
      end
      default: begin
        n.seq = SEQ_IDLE;
      end
    endcase

    // in zero-cross mode results take the latest computed values only
    // at a crossing, which hides ripple at the cost of update rate
    if (zx_mode && zero_cross_in) begin
      n.irms = irms_sat;
      n.voltage_rms_result = q.voltage_rms_result_new;
    end

    // rms waveform stream
    if (q.wave_cnt >= wave_period - 15'h0001) begin
      n.wave_cnt = 15'h0000;
      if (q.irq_en[`BIT_WAVE_IRQ_EN]) begin
        if (wave_src == `WAVE_SRC_IRMS) begin
          n.wave_valid = 1'b1;
          n.wave_data  = q.irms_raw[23:0];
        end else if (wave_src == `WAVE_SRC_VOLTAGE_RMS_RESULT) begin
          n.wave_valid = 1'b1;
          n.wave_data  = q.voltage_rms_result_new;
        end
      end
    end else begin
      n.wave_cnt = q.wave_cnt + 15'h0001;
    end

    // register writes
    if (wr_in) begin
      case (addr_in)
        `OFS_MODE_CONTROL_TWO: n.mode_control_two    = wdata_in[7:0];
        `OFS_WAVE_SOURCE:      n.wave_sel = wdata_in[7:0];
        `OFS_IRQ_ENABLE_HIGH:  n.irq_en   = wdata_in[7:0];
        `OFS_IRMS_OFFSET:      n.irms_os  = wdata_in[11:0];
        `OFS_VOLTAGE_RMS_RESULT_OFFSET:      n.voltage_rms_result_os  = wdata_in[11:0];
        `OFS_PHASE_TRIM: begin
          if (wr_phase < $signed(`PHASE_MIN)) begin
            n.phase = `PHASE_MIN;
          end else if (wr_phase > $signed(`PHASE_MAX)) begin
            n.phase = `PHASE_MAX;
          end else begin
            n.phase = wdata_in[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, answered in the following cycle
    if (rd_in) begin
      case (addr_in)
        `OFS_MODE_CONTROL_TWO: n.rdata = {16'h0000, q.mode_control_two};
        `OFS_WAVE_SOURCE:      n.rdata = {16'h0000, q.wave_sel};
        `OFS_IRQ_ENABLE_HIGH:  n.rdata = {16'h0000, q.irq_en};
        `OFS_PHASE_TRIM:       n.rdata = {16'h0000, q.phase};
        `OFS_IRMS_OFFSET:      n.rdata = {12'h000, q.irms_os};
        `OFS_VOLTAGE_RMS_RESULT_OFFSET:      n.rdata = {12'h000, q.voltage_rms_result_os};
        `OFS_IRMS_RESULT:      n.rdata = q.irms;
        `OFS_VOLTAGE_RMS_RESULT_RESULT:      n.rdata = q.voltage_rms_result;
        `OFS_WAVE_SAMPLE:      n.rdata = q.wave_data;
        default:               n.rdata = `RST_RESULT;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q          <= '0;
      q.phase    <= `RST_PHASE_TRIM;
      q.mode_control_two    <= `RST_BYTE;
      q.wave_sel <= `RST_BYTE;
      q.irq_en   <= `RST_BYTE;
      q.irms_os  <= `RST_OFFSET;
      q.voltage_rms_result_os  <= `RST_OFFSET;
      q.seq      <= SEQ_IDLE;
    end else begin
      q <= n;
    end
  end

  assign rdata_out        = q.rdata;
  assign cur_aligned_out  = q.cur_al;
  assign volt_aligned_out = q.volt_al;
  assign sample_tick_out  = q.tick;
  assign wave_sample_out  = q.wave_data;
  assign wave_valid_out   = q.wave_valid;
endmodule

// ===== phase_rms_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  phase compensation and rms block.
  Assumes a 50 MHz clock and an 8-bit register address space.
*/
`ifndef PHASE_RMS_REGS_SVH
`define PHASE_RMS_REGS_SVH

`define OFS_MODE_CONTROL_TWO 8'h0C
`define OFS_WAVE_SOURCE      8'h0D
`define OFS_PHASE_TRIM       8'h20
`define OFS_IRMS_OFFSET      8'h21
`define OFS_VOLTAGE_RMS_RESULT_OFFSET      8'h22
`define OFS_IRMS_RESULT      8'h23
`define OFS_VOLTAGE_RMS_RESULT_RESULT      8'h24
`define OFS_IRQ_ENABLE_HIGH  8'h25
`define OFS_WAVE_SAMPLE      8'h26

`define BIT_ZX_RMS           4
`define BIT_WAVE_IRQ_EN      0
`define WAVE_SRC_LSB         0
`define WAVE_SRC_MSB         1
`define WAVE_RATE_LSB        2
`define WAVE_RATE_MSB        3
`define WAVE_SRC_IRMS        2'h2
`define WAVE_SRC_VOLTAGE_RMS_RESULT        2'h3

`define PHASE_CENTRE         8'h40
`define PHASE_MIN            8'h82
`define PHASE_MAX            8'h68
`define RST_PHASE_TRIM       `PHASE_CENTRE
`define RST_BYTE             8'h00
`define RST_OFFSET           12'h000
`define RST_RESULT           24'h000000
`define HIST_LAST            8'hFF

`define CLK_HZ               50000000
`define CLK_PERIOD_NS        20
`define STEP_TIME_NS         1220
`define STEP_CYCLES          (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define WAVE_RATE_SPS        27900
`define WAVE_BASE_CYCLES     (`CLK_HZ / `WAVE_RATE_SPS)

`define LPF_SHIFT            16
`define IRMS_OFS_SHIFT       15
`define VOLTAGE_RMS_RESULT_OFS_SHIFT       6
`define ROOT_STEPS           25
`define RMS_MAX              24'hFFFFFF

`endif

// ===== phase_rms_pkg.sv
/*
  Types shared by the phase compensation and rms block.
  Assumes the register header is on the include path.
*/
package phase_rms_pkg;
  `include "phase_rms_regs.svh"

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ROOT_I, SEQ_ROOT_V} seq_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [4:0]  cnt;
    logic [49:0] rad;
    logic [27:0] rem;
    logic [24:0] root;
  } root_state_t;

  typedef struct packed {
    logic [5:0]  step_cnt;
    logic [14:0] wave_cnt;
    logic [7:0]  wr_ptr;
    logic        hist_full;
    logic [7:0]  mode_control_two;
    logic [7:0]  wave_sel;
    logic [7:0]  phase;
    logic [11:0] irms_os;
    logic [11:0] voltage_rms_result_os;
    logic [7:0]  irq_en;
    logic [23:0] irms;
    logic [23:0] voltage_rms_result;
    logic [24:0] irms_raw;
    logic [23:0] voltage_rms_result_new;
    logic [63:0] acc_i;
    logic [63:0] acc_v;
    logic [23:0] cur_al;
    logic [23:0] volt_al;
    logic        tick;
    logic [23:0] wave_data;
    logic        wave_valid;
    logic [23:0] rdata;
    seq_t        seq;
    logic        start;
    logic [49:0] rad;
  } main_state_t;
endpackage

// ===== sqrt_if.sv
/*
  Request and answer signals between the rms sequencer and the root unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface sqrt_if;
  logic        start;
  logic [49:0] radicand;
  logic        done;
  logic [24:0] root;
  modport requester (output start, output radicand, input done, input root);
  modport solver (input start, input radicand, output done, output root);
endinterface

// ===== isqrt_unit.sv
/*
  Bit-serial integer square root: 50-bit radicand, 25-bit root,
  one root bit per clock, done pulses in the same cycle as the last bit.
  Assumes start is a one-cycle pulse; a new start aborts a running root.
*/
`timescale 1ns/10ps
module isqrt_unit
  import phase_rms_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  sqrt_if.solver    port
);
  root_state_t q;
  root_state_t n;
  logic [27:0] trial;
  logic [27:0] rem_t;

  always_comb begin
    n     = q;
    n.done = 1'b0;
    trial = {1'b0, q.root, 2'b01};
    rem_t = {q.rem[25:0], q.rad[49:48]};
    if (port.start) begin
      n.busy = 1'b1;
      n.cnt  = 5'h00;
      n.rad  = port.radicand;
      n.rem  = 28'h0000000;
      n.root = 25'h0000000;
    end else if (q.busy) begin
      if (rem_t >= trial) begin
        n.rem  = rem_t - trial;
        n.root = {q.root[23:0], 1'b1};
      end else begin
        n.rem  = rem_t;
        n.root = {q.root[23:0], 1'b0};
      end
      n.rad = {q.rad[47:0], 2'b00};
      if (q.cnt == 5'(`ROOT_STEPS - 1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = q.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign port.done = q.done;
  assign port.root = q.root;
endmodule

// ===== phase_rms_chk_sva.sv
/*
  Port checker for phase_comp_rms_calc: bus answers, step cadence,
  aligned sample timing and the rms waveform stream.
  Assumes one clock, async active-low reset, header on the include path.
*/
`timescale 1ns/10ps
`include "phase_rms_regs.svh"
module phase_rms_chk
  import phase_rms_pkg::*;
#(
  parameter int WAVE_BASE_CYCLES = `WAVE_BASE_CYCLES
)(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [23:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [23:0] rdata_out,
  input wire logic [23:0] cur_sample_in,
  input wire logic [23:0] volt_sample_in,
  input wire logic        zero_cross_in,
  input wire logic [23:0] cur_aligned_out,
  input wire logic [23:0] volt_aligned_out,
  input wire logic        sample_tick_out,
  input wire logic [23:0] wave_sample_out,
  input wire logic        wave_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] tgap_q;
  logic [15:0] wgap_q;
  logic [15:0] wlen;
  logic        seen_t_q;
  logic        seen_w_q;
  logic        cfg_q;
  logic [1:0]  src_q;
  logic        irq_q;
  logic        ok;
  logic [7:0]  trim_q;
  function automatic logic [7:0] clamp(input logic [7:0] w);
    if ($signed(w) < -126) return 8'h82;
    if ($signed(w) > 104) return 8'h68;
    return w;
  endfunction
  assign wlen = wgap_q + 16'h1;
  assign ok = irq_q && src_q[1];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgap_q <= 16'h0;
      wgap_q <= 16'h0;
      seen_t_q <= 1'b0;
      seen_w_q <= 1'b0;
      cfg_q <= 1'b0;
      src_q <= 2'h0;
      irq_q <= 1'b0;
      trim_q <= 8'h40;
    end else begin
      tgap_q <= sample_tick_out ? 16'h0 : tgap_q + 16'h1;
      wgap_q <= wave_valid_out ? 16'h0 : wgap_q + 16'h1;
      seen_t_q <= seen_t_q | sample_tick_out;
      seen_w_q <= seen_w_q | wave_valid_out;
      // a config write spoils the next measured wave gap
      if (wr_in && (addr_in == `OFS_WAVE_SOURCE || addr_in == `OFS_IRQ_ENABLE_HIGH)) cfg_q <= 1'b1;
      else if (wave_valid_out) cfg_q <= 1'b0;
      if (wr_in && addr_in == `OFS_WAVE_SOURCE) src_q <= wdata_in[1:0];
      if (wr_in && addr_in == `OFS_IRQ_ENABLE_HIGH) irq_q <= wdata_in[0];
      if (wr_in && addr_in == `OFS_PHASE_TRIM) trim_q <= clamp(wdata_in[7:0]);
    end
  end
  sequence s_trim_rd;
    rd_in && addr_in == `OFS_PHASE_TRIM;
  endsequence
  sequence s_hole_rd;
    rd_in && !(addr_in inside {8'h0C, 8'h0D, [8'h20:8'h26]});
  endsequence
  chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 24'h0)
    else $error("read data not zero outside read answer");
  chk_trim_readback: assert property (s_trim_rd |=> rdata_out == {16'h0, $past(trim_q)})
    else $error("phase trim readback wrong");
  chk_unmapped_read: assert property (s_hole_rd |=> rdata_out == 24'h0)
    else $error("unmapped read not zero");
  chk_step_period: assert property (sample_tick_out && seen_t_q |-> tgap_q == 16'd60)
    else $error("step period not 61 cycles");
  chk_aligned_on_step: assert property (($changed(cur_aligned_out) || $changed(volt_aligned_out)) |-> sample_tick_out)
    else $error("aligned samples changed off step");
  chk_aligned_hold: assert property (sample_tick_out |=> ($stable(cur_aligned_out) && $stable(volt_aligned_out)) [*8])
    else $error("aligned samples not held");
  chk_wave_period: assert property (wave_valid_out && seen_w_q && !cfg_q |-> wlen == 16'(WAVE_BASE_CYCLES) ||
    wlen == 16'(WAVE_BASE_CYCLES * 2) || wlen == 16'(WAVE_BASE_CYCLES * 4) || wlen == 16'(WAVE_BASE_CYCLES * 8))
    else $error("wave sample period illegal");
  chk_wave_gate: assert property (wave_valid_out |-> ok || $past(ok))
    else $error("wave sample while stream disabled");
endmodule

bind phase_comp_rms_calc phase_rms_chk #(.WAVE_BASE_CYCLES(WAVE_BASE_CYCLES)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .cur_sample_in(cur_sample_in), .volt_sample_in(volt_sample_in),
  .zero_cross_in(zero_cross_in), .cur_aligned_out(cur_aligned_out), .volt_aligned_out(volt_aligned_out),
  .sample_tick_out(sample_tick_out), .wave_sample_out(wave_sample_out), .wave_valid_out(wave_valid_out));

// ===== adc_sample_model.sv
/*
  Sample source for the current and voltage channels.
  Assumes the block's clock; ramp mode counts up every clock.
*/
`timescale 1ns/10ps
module adc_sample_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ramp_in,
  output logic      [23:0] cur_out,
  output logic      [23:0] volt_out
);
  logic [23:0] cnt_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt_q <= 24'h0;
    else cnt_q <= ramp_in ? cnt_q + 24'h1 : 24'h0;
  end
  // same value on both channels, so any lag shows as a count difference
  assign cur_out = cnt_q;
  assign volt_out = cnt_q;
endmodule

// ===== testbench.sv
/*
  Self-checking bench for phase_comp_rms_calc over its strobe register port.
  Assumes the sample model drives both channels and WAVE_BASE_CYCLES is 8.
*/
`timescale 1ns/10ps
`include "phase_rms_regs.svh"
module testbench
  import phase_rms_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        zero_cross_in = 1'b0;
  logic        ramp = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [23:0] wdata_in = 24'h0;
  logic [23:0] rdata_out, cur_sample_in, volt_sample_in, cur_aligned_out, volt_aligned_out, wave_sample_out;
  logic        sample_tick_out, wave_valid_out;
  int          err_count = 0;
  int          n_compared = 0;
  int          c;
  logic [7:0]  tw[5] = '{8'h3C, 8'h80, 8'h70, 8'h82, 8'h68};
  logic [7:0]  te[5] = '{8'h3C, 8'h82, 8'h68, 8'h82, 8'h68};
  logic [7:0]  tr[4] = '{8'h40, 8'h3C, 8'h68, 8'h82};
  always #10 clk_in = ~clk_in;
  adc_sample_model adc (.clk_in(clk_in), .rst_n_in(rst_n_in), .ramp_in(ramp),
    .cur_out(cur_sample_in), .volt_out(volt_sample_in));
  phase_comp_rms_calc #(.WAVE_BASE_CYCLES(8)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .cur_sample_in(cur_sample_in), .volt_sample_in(volt_sample_in),
    .zero_cross_in(zero_cross_in), .cur_aligned_out(cur_aligned_out), .volt_aligned_out(volt_aligned_out),
    .sample_tick_out(sample_tick_out), .wave_sample_out(wave_sample_out), .wave_valid_out(wave_valid_out));
  task automatic check(input string n, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(n, exp, rdata_out);
  endtask
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin @(posedge clk_in); #1; k++; end while (sample_tick_out !== 1'b1 && k < 100);
      if (sample_tick_out !== 1'b1) begin
        err_count++;
        $display("ERROR sample tick expected 1 seen %b", sample_tick_out);
      end
    end
  endtask
  // stops at 300 so a missing stream still returns
  task automatic wave(output int n);
    n = 0;
    do begin @(posedge clk_in); #1; n++; end while (wave_valid_out !== 1'b1 && n < 300);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(20 * 60000);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk("trim reset", `OFS_PHASE_TRIM, 24'h40);
    rd_chk("mode reset", `OFS_MODE_CONTROL_TWO, 24'h0);
    rd_chk("irms reset", `OFS_IRMS_RESULT, 24'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_PHASE_TRIM, {16'h0, tw[i]});
      rd_chk("trim", `OFS_PHASE_TRIM, {16'h0, te[i]});
    end
    rd_chk("hole", 8'h30, 24'h0);
    wr(`OFS_VOLTAGE_RMS_RESULT_RESULT, 24'h123456);
    rd_chk("voltage_rms_result read only", `OFS_VOLTAGE_RMS_RESULT_RESULT, 24'h0);
    wr(`OFS_VOLTAGE_RMS_RESULT_OFFSET, 24'h5);
    ticks(3);
    rd_chk("voltage_rms_result offset", `OFS_VOLTAGE_RMS_RESULT_RESULT, 24'h140);
    wr(`OFS_VOLTAGE_RMS_RESULT_OFFSET, 24'hFFB);
    ticks(3);
    rd_chk("voltage_rms_result clamp", `OFS_VOLTAGE_RMS_RESULT_RESULT, 24'h0);
    wr(`OFS_IRMS_OFFSET, 24'h2);
    ticks(3);
    rd_chk("irms offset", `OFS_IRMS_RESULT, 24'h100);
    rd_chk("irms offset reg", `OFS_IRMS_OFFSET, 24'h2);
    wr(`OFS_IRMS_OFFSET, 24'h800);
    ticks(3);
    rd_chk("irms clamp", `OFS_IRMS_RESULT, 24'h0);
    wr(`OFS_IRMS_OFFSET, 24'h2);
    ticks(3);
    wr(`OFS_MODE_CONTROL_TWO, 24'h10);
    wr(`OFS_IRMS_OFFSET, 24'h8);
    wr(`OFS_VOLTAGE_RMS_RESULT_OFFSET, 24'h1);
    ticks(4);
    rd_chk("irms held", `OFS_IRMS_RESULT, 24'h100);
    rd_chk("voltage_rms_result held", `OFS_VOLTAGE_RMS_RESULT_RESULT, 24'h0);
    @(posedge clk_in);
    zero_cross_in <= 1'b1;
    @(posedge clk_in);
    zero_cross_in <= 1'b0;
    rd_chk("irms zero cross", `OFS_IRMS_RESULT, 24'h200);
    rd_chk("voltage_rms_result zero cross", `OFS_VOLTAGE_RMS_RESULT_RESULT, 24'h40);
    wr(`OFS_MODE_CONTROL_TWO, 24'h0);
    wr(`OFS_IRQ_ENABLE_HIGH, 24'h1);
    wr(`OFS_WAVE_SOURCE, 24'h3);
    wave(c);
    check("wave voltage_rms_result", 24'h40, wave_sample_out);
    wr(`OFS_WAVE_SOURCE, 24'h2);
    wave(c);
    wave(c);
    check("wave irms", 24'h200, wave_sample_out);
    for (int r = 0; r < 4; r++) begin
      wr(`OFS_WAVE_SOURCE, 24'(r * 4 + 2));
      wave(c);
      wave(c);
      check("wave period", 24'(8 << r), 24'(c));
    end
    wr(`OFS_IRQ_ENABLE_HIGH, 24'h0);
    wave(c);
    check("wave gated", 24'd300, 24'(c));
    @(posedge clk_in);
    ramp <= 1'b1;
    ticks(240);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_PHASE_TRIM, {16'h0, tr[i]});
      ticks(2);
      check("lag", 24'(61 * (int'($signed(tr[i])) - 64)), cur_aligned_out - volt_aligned_out);
    end
    wrap_up();
  end
endmodule
